// File: design/snw_defines.vh
`ifndef SNW_DEFINES_VH
`define SNW_DEFINES_VH
`define SNW_CLK_HZ          100000000
`define SNW_TICK_MS         1
`define SNW_ADR_SLEEP_DUR   8'h00
`define SNW_ADR_POLL_PER    8'h04
`define SNW_ADR_STANDBY     8'h08
`define SNW_ADR_REJOIN      8'h0C
`define SNW_ADR_NS_POLL     8'h10
`define SNW_ADR_PIN_FUNC    8'h14
`define SNW_ADR_CTRL        8'h18
`define SNW_ADR_STATUS      8'h1C
`define SNW_ADR_PARENT_TO   8'h20
`define SNW_RST_SLEEP_DUR   16'h0008
`define SNW_RST_POLL_PER    16'h0064
`define SNW_RST_STANDBY     16'h0005
`define SNW_RST_REJOIN      16'h000A
`define SNW_RST_NS_POLL     16'h0005
`define SNW_RST_PARENT_TO   16'h003C
`define SNW_RST_PIN_FUNC    3'h0
`define SNW_PIN_FUNC_ALT    3'h5
`define SNW_MS_PER_QSEC     16'h00FA
`define SNW_MS_PER_SEC      16'h03E8
`define SNW_CTRL_SLEEPY     0
`define SNW_CTRL_LINK_UP    1
`define SNW_ST_ASLEEP       0
`define SNW_ST_RADIO        1
`define SNW_ST_REJOINS      2
`endif

// File: design/snw_tick.v
`include "snw_defines.vh"
module snw_tick #(
   parameter CLK_HZ = `SNW_CLK_HZ
) (
   // Clock and reset
   input  wire clk,
   input  wire arst_n,
   // Millisecond pulse
   output reg  tick_ms
);
   localparam integer DIV = CLK_HZ / 1000 * `SNW_TICK_MS;
   reg [31:0] cnt;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 32'h0000_0000;
         tick_ms <= 1'b0;
      end else if (cnt == DIV - 1) begin
         cnt <= 32'h0000_0000;
         tick_ms <= 1'b1;
      end else begin
         cnt <= cnt + 32'h0000_0001;
         tick_ms <= 1'b0;
      end
   end
endmodule

// File: design/snw_wake_ctrl.v
// Chosen here: the address map and the Wishbone slave port.
`include "snw_defines.vh"
module snw_wake_ctrl #(
   parameter CLK_HZ = `SNW_CLK_HZ
) (
   // Clock and reset
   input  wire        clk,
   input  wire        arst_n,
   // Classic Wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // Pins and traffic events
   input  wire        wake_pin,
   input  wire        serial_rx,
   input  wire        traffic,
   // Radio side
   output reg         radio_on,
   output reg         poll_req,
   output reg         rejoin_req
);
   localparam [1:0] S_AWAKE = 2'd0;
   localparam [1:0] S_SLEEP = 2'd1;

   wire        tick;
   reg  [1:0]  state;
   reg  [15:0] sleep_dur;
   reg  [15:0] poll_per;
   reg  [15:0] standby_to;
   reg  [15:0] rejoin_to;
   reg  [15:0] ns_poll;
   reg  [15:0] parent_to;
   reg  [2:0]  pin_func;
   reg         sleepy;
   reg         link_up;
   reg  [15:0] rejoin_count;
   reg  [31:0] sleep_cnt;
   reg  [31:0] poll_cnt;
   reg  [31:0] standby_cnt;
   reg  [31:0] rejoin_cnt;
   reg  [2:0]  pin_sync;
   reg  [2:0]  rx_sync;
   wire        pin_fall;
   wire        rx_edge;
   wire        pin_wake;
   wire        bus_req;
   wire        wr;

   snw_tick #(
      .CLK_HZ (CLK_HZ)
   ) u_tick (
      .clk     (clk),
      .arst_n  (arst_n),
      .tick_ms (tick)
   );

   function [31:0] to_ms;
      input [15:0] val;
      input [15:0] unit_ms;
      begin
         to_ms = {16'h0000, val} * {16'h0000, unit_ms};
      end
   endfunction

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  sel;
      begin
         merge16 = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   // Pins are asynchronous; the third stage only feeds edge detection.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_sync <= 3'b111;
         rx_sync <= 3'b111;
      end else begin
         pin_sync <= {pin_sync[1:0], wake_pin};
         rx_sync <= {rx_sync[1:0], serial_rx};
      end
   end
   assign pin_fall = pin_sync[2] & ~pin_sync[1];
   // A start bit is a falling edge of the idle-high receive line.
   assign rx_edge = rx_sync[2] & ~rx_sync[1];
   assign pin_wake = pin_fall && (pin_func == `SNW_PIN_FUNC_ALT);

   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr = bus_req & wb_we_i & ~wb_ack_o;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sleep_dur <= `SNW_RST_SLEEP_DUR;
         poll_per <= `SNW_RST_POLL_PER;
         standby_to <= `SNW_RST_STANDBY;
         rejoin_to <= `SNW_RST_REJOIN;
         ns_poll <= `SNW_RST_NS_POLL;
         parent_to <= `SNW_RST_PARENT_TO;
         pin_func <= `SNW_RST_PIN_FUNC;
         sleepy <= 1'b1;
         link_up <= 1'b1;
      end else if (wr) begin
         case (wb_adr_i)
            `SNW_ADR_SLEEP_DUR: sleep_dur <= merge16(sleep_dur, wb_dat_i, wb_sel_i);
            `SNW_ADR_POLL_PER:  poll_per <= merge16(poll_per, wb_dat_i, wb_sel_i);
            `SNW_ADR_STANDBY:   standby_to <= merge16(standby_to, wb_dat_i, wb_sel_i);
            `SNW_ADR_REJOIN:    rejoin_to <= merge16(rejoin_to, wb_dat_i, wb_sel_i);
            `SNW_ADR_NS_POLL:   ns_poll <= merge16(ns_poll, wb_dat_i, wb_sel_i);
            `SNW_ADR_PARENT_TO: parent_to <= merge16(parent_to, wb_dat_i, wb_sel_i);
            `SNW_ADR_PIN_FUNC: begin
               if (wb_sel_i[0]) begin
                  pin_func <= wb_dat_i[2:0];
               end
            end
            `SNW_ADR_CTRL: begin
               if (wb_sel_i[0]) begin
                  sleepy <= wb_dat_i[`SNW_CTRL_SLEEPY];
                  link_up <= wb_dat_i[`SNW_CTRL_LINK_UP];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // One wait state: ack rises the cycle after the request and falls next.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         case (wb_adr_i)
            `SNW_ADR_SLEEP_DUR: wb_dat_o <= {16'h0000, sleep_dur};
            `SNW_ADR_POLL_PER:  wb_dat_o <= {16'h0000, poll_per};
            `SNW_ADR_STANDBY:   wb_dat_o <= {16'h0000, standby_to};
            `SNW_ADR_REJOIN:    wb_dat_o <= {16'h0000, rejoin_to};
            `SNW_ADR_NS_POLL:   wb_dat_o <= {16'h0000, ns_poll};
            `SNW_ADR_PARENT_TO: wb_dat_o <= {16'h0000, parent_to};
            `SNW_ADR_PIN_FUNC:  wb_dat_o <= {29'h0000_0000, pin_func};
            `SNW_ADR_CTRL:      wb_dat_o <= {30'h0000_0000, link_up, sleepy};
            `SNW_ADR_STATUS:    wb_dat_o <= {rejoin_count, 13'h0000, rejoin_req, radio_on, state == S_SLEEP};
            default:            wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Sleep, poll and standby sequencing. Poll period in awake sleepy mode
   // comes from the awake poll period; the non-sleepy setting is unused then.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_AWAKE;
         radio_on <= 1'b1;
         poll_req <= 1'b0;
         sleep_cnt <= 32'h0000_0000;
         poll_cnt <= 32'h0000_0000;
         standby_cnt <= 32'h0000_0000;
      end else begin
         poll_req <= 1'b0;
         case (state)
            S_AWAKE: begin
               radio_on <= 1'b1;
               if (traffic || rx_edge) begin
                  standby_cnt <= 32'h0000_0000;
               end else if (tick) begin
                  standby_cnt <= standby_cnt + 32'h0000_0001;
               end
               if (tick) begin
                  if (poll_cnt + 32'h0000_0001 >= (sleepy ? to_ms(poll_per, 16'h0001)
                                                           : to_ms(ns_poll, `SNW_MS_PER_SEC))) begin
                     poll_cnt <= 32'h0000_0000;
                     poll_req <= 1'b1;
                  end else begin
                     poll_cnt <= poll_cnt + 32'h0000_0001;
                  end
               end
               if (sleepy && !traffic && !rx_edge && tick &&
                   standby_cnt + 32'h0000_0001 >= to_ms(standby_to, `SNW_MS_PER_SEC)) begin
                  state <= S_SLEEP;
                  radio_on <= 1'b0;
                  // A poll that falls on this tick would leave with the radio already off.
                  poll_req <= 1'b0;
                  sleep_cnt <= 32'h0000_0000;
               end
            end
            S_SLEEP: begin
               radio_on <= 1'b0;
               if (tick) begin
                  sleep_cnt <= sleep_cnt + 32'h0000_0001;
               end
               // Sleep duration replaces the awake poll period here.
               if (pin_wake || rx_edge || !sleepy ||
                   (tick && sleep_cnt + 32'h0000_0001 >= to_ms(sleep_dur, `SNW_MS_PER_QSEC))) begin
                  state <= S_AWAKE;
                  radio_on <= 1'b1;
                  standby_cnt <= 32'h0000_0000;
                  poll_cnt <= 32'h0000_0000;
                  poll_req <= 1'b1;
               end
            end
            default: begin
               state <= S_AWAKE;
            end
         endcase
      end
   end

   // Rejoin after the parent link has stayed broken for the rejoin timeout.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rejoin_cnt <= 32'h0000_0000;
         rejoin_req <= 1'b0;
         rejoin_count <= 16'h0000;
      end else begin
         rejoin_req <= 1'b0;
         if (link_up) begin
            rejoin_cnt <= 32'h0000_0000;
         end else if (tick) begin
            if (rejoin_cnt + 32'h0000_0001 >= to_ms(rejoin_to, `SNW_MS_PER_SEC)) begin
               rejoin_cnt <= 32'h0000_0000;
               rejoin_req <= 1'b1;
               rejoin_count <= rejoin_count + 16'h0001;
            end else begin
               rejoin_cnt <= rejoin_cnt + 32'h0000_0001;
            end
         end
      end
   end
endmodule

// File: verification/snw_host_model.sv
module snw_host_model #(parameter int TO_CLK = 600000) (
   // Clock and radio side
   input  wire  clk,
   input  wire  poll_req,
   // Host pins and parent status
   output logic wake_pin,
   output logic serial_rx,
   output logic dropped
);
   timeunit 1ns;
   timeprecision 1ps;
   int idle = 0;
   initial begin
      wake_pin = 1'b1;
      serial_rx = 1'b1;
      dropped = 1'b0;
   end
   // The parent forgets a child that stays silent past its poll timeout.
   always @(posedge clk) begin
      idle <= poll_req ? 0 : idle + 1;
      dropped <= dropped | (idle >= TO_CLK);
   end
   // A host would pin-wake before data; rx alone exercises the serial wake path.
   task automatic drop(input bit rx);
      @(posedge clk);
      if (rx) serial_rx <= 1'b0;
      else wake_pin <= 1'b0;
      repeat (4) @(posedge clk);
      serial_rx <= 1'b1;
      wake_pin <= 1'b1;
   endtask
endmodule

// File: verification/snw_wake_ctrl_sva.sv
module snw_wake_ctrl_sva #(parameter CLK_HZ = 100000000) (
   input wire        clk,
   input wire        arst_n,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        wake_pin,
   input wire        serial_rx,
   input wire        traffic,
   input wire        radio_on,
   input wire        poll_req,
   input wire        rejoin_req
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_wake; !radio_on ##1 radio_on; endsequence
   // A pin or receive edge, or a control write, may legally end a sleep early.
   sequence s_slept; $fell(radio_on) && $past(wake_pin) && $past(serial_rx); endsequence
   sequence s_quiet; wake_pin && serial_rx && !(wb_cyc_i && wb_we_i); endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_unmapped_zero: assert property (s_req and (!wb_we_i && wb_adr_i == 8'h24) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_poll_pulse: assert property (poll_req |=> !poll_req) else $error("poll too long");
   a_rejoin_pulse: assert property (rejoin_req |=> !rejoin_req) else $error("rejoin too long");
   a_poll_awake: assert property (poll_req |-> radio_on) else $error("poll while asleep");
   a_wake_poll: assert property (s_wake |-> ##[0:2] poll_req) else $error("no poll on wake");
   a_sleep_hold: assert property (s_slept ##0 s_quiet [*8] |-> !radio_on) else $error("woke with no source");
   a_quiet_sleep: assert property ($fell(radio_on) |-> $past(traffic, 2) == 1'b0) else $error("slept on traffic");
endmodule
bind snw_wake_ctrl snw_wake_ctrl_sva #(.CLK_HZ(CLK_HZ)) u_sva (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_dat_o, .wb_ack_o, .wake_pin, .serial_rx, .traffic, .radio_on, .poll_req, .rejoin_req);

// File: verification/snw_wake_ctrl_tb_top.sv
`include "snw_defines.vh"
module snw_wake_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HZ = 10000;
   logic        clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, traffic = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000, rd;
   wire  [31:0] dat_o;
   wire         ack, wake_pin, serial_rx, radio_on, poll_req, rejoin_req, dropped;
   int          n_errors = 0, cmp_count = 0, cyc_cnt = 0, n;
   always #5 clk = ~clk;
   snw_wake_ctrl #(.CLK_HZ(HZ)) u_snw_wake_ctrl (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .wake_pin(wake_pin), .serial_rx(serial_rx), .traffic(traffic), .radio_on(radio_on),
      .poll_req(poll_req), .rejoin_req(rejoin_req));
   // The parent timeout is scaled down to 2 s so that a silent child can really be dropped in a run.
   snw_host_model #(.TO_CLK(2 * HZ)) u_snw_host_model (.clk(clk), .poll_req(poll_req), .wake_pin(wake_pin),
      .serial_rx(serial_rx), .dropped(dropped));
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 90000) begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h0000_0001);
   endtask
   // The request holds until ack is sampled high, then drops for at least a cycle.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic wr(input logic lvl);
      n = 0;
      while (radio_on !== lvl) begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic pulse;
      @(posedge clk);
      traffic <= 1'b1;
      @(posedge clk);
      traffic <= 1'b0;
   endtask
   task automatic t_reset;
      rdchk(`SNW_ADR_SLEEP_DUR, 32'h0000_0008);
      rdchk(`SNW_ADR_POLL_PER, 32'h0000_0064);
      rdchk(`SNW_ADR_STANDBY, 32'h0000_0005);
      rdchk(`SNW_ADR_REJOIN, 32'h0000_000A);
      rdchk(`SNW_ADR_NS_POLL, 32'h0000_0005);
      rdchk(`SNW_ADR_PARENT_TO, 32'h0000_003C);
      rdchk(`SNW_ADR_PIN_FUNC, 32'h0000_0000);
      rdchk(`SNW_ADR_CTRL, 32'h0000_0003);
      rdchk(`SNW_ADR_STATUS, 32'h0000_0002);
      rdchk(8'h24, 32'h0000_0000);
      $display("reset test done");
   endtask
   // Short settings: 250 ms sleep, 2 ms poll, 1 s standby and rejoin.
   task automatic t_poll;
      wb(1'b1, `SNW_ADR_SLEEP_DUR, 32'h0000_0001);
      wb(1'b1, `SNW_ADR_POLL_PER, 32'h0000_0002);
      wb(1'b1, `SNW_ADR_STANDBY, 32'h0000_0001);
      wb(1'b1, `SNW_ADR_REJOIN, 32'h0000_0001);
      repeat (1100) @(posedge clk);
      pulse();
      n = 0;
      repeat (400) begin
         @(posedge clk);
         if (poll_req === 1'b1) n++;
      end
      rng(n, 19, 21);
      $display("poll test done");
   endtask
   task automatic t_standby;
      n = 0;
      repeat (3) begin
         repeat (6000) begin
            @(posedge clk);
            if (radio_on !== 1'b1) n++;
         end
         pulse();
      end
      chk(n, 32'h0000_0000);
      wr(1'b0);
      rng(n, 9980, 10030);
      wr(1'b1);
      rng(n, 2470, 2530);
      $display("standby and timer test done");
   endtask
   task automatic t_wake;
      wr(1'b0);
      u_snw_host_model.drop(1'b0);
      repeat (20) @(posedge clk);
      chk({31'h0, radio_on}, 32'h0000_0000);
      wb(1'b1, `SNW_ADR_PIN_FUNC, 32'h0000_0005);
      u_snw_host_model.drop(1'b0);
      wr(1'b1);
      rng(n, 0, 10);
      wr(1'b0);
      u_snw_host_model.drop(1'b1);
      wr(1'b1);
      rng(n, 0, 10);
      $display("wake source test done");
   endtask
   task automatic t_rejoin;
      wb(1'b1, `SNW_ADR_CTRL, 32'h0000_0001);
      n = 0;
      while (rejoin_req !== 1'b1) begin
         @(posedge clk);
         n++;
      end
      rng(n, 9980, 10030);
      wb(1'b0, `SNW_ADR_STATUS, 32'h0000_0000);
      chk({16'h0000, rd[31:16]}, 32'h0000_0001);
      chk({31'h0, dropped}, 32'h0000_0000);
      $display("rejoin test done");
   endtask
   // Non-sleepy mode with a 1 s poll period: the radio stays on and polls twice in 2.1 s.
   task automatic t_nonsleepy;
      int off;
      wb(1'b1, `SNW_ADR_NS_POLL, 32'h0000_0001);
      wb(1'b1, `SNW_ADR_CTRL, 32'h0000_0002);
      wr(1'b1);
      off = 0;
      n = 0;
      repeat (21000) begin
         @(posedge clk);
         if (poll_req === 1'b1) n++;
         if (radio_on !== 1'b1) off++;
      end
      rng(n, 2, 2);
      chk(off, 32'h0000_0000);
      chk({31'h0, dropped}, 32'h0000_0000);
      $display("non-sleepy test done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_reset();
      t_poll();
      t_standby();
      t_wake();
      t_rejoin();
      t_nonsleepy();
      final_report();
   end
endmodule
